// >>> common/esim_pkg.sv
`default_nettype none
// ****************************************************************
// Encoder simulation constants
// ****************************************************************
package esim_pkg;
   // Simulation mode codes
   localparam logic [1:0] MODE_HW        = 2'h0;
   localparam logic [1:0] MODE_LPR       = 2'h1;
   // Output format codes
   localparam logic [1:0] FMT_QUAD       = 2'h0;
   localparam logic [1:0] FMT_FD         = 2'h1;
   localparam logic [1:0] FMT_FR         = 2'h2;
   // Status codes
   localparam logic [1:0] STAT_NONE      = 2'h0;
   localparam logic [1:0] STAT_FULL      = 2'h1;
   localparam logic [1:0] STAT_NO_MARKER = 2'h2;
   // Position source codes
   localparam logic [1:0] SRC_PRIMARY    = 2'h0;
   localparam logic [1:0] SRC_SECONDARY  = 2'h1;
   localparam logic [1:0] SRC_AUX        = 2'h2;
   // Primary input device type codes
   localparam logic [2:0] DEV_QUAD       = 3'h1;
   localparam logic [2:0] DEV_FD         = 3'h2;
   localparam logic [2:0] DEV_FR         = 3'h3;
   localparam logic [2:0] DEV_SINE_COS   = 3'h4;
   localparam logic [2:0] DEV_SINE_COS_SER = 3'h5;
   // Widths and limits
   localparam int         POS_W          = 16;
   localparam int         LINES_W        = 15;
   localparam logic [14:0] LINES_MAX     = 15'h4000;
   localparam int         ACC_W          = 32;
   localparam int         ACC_SHIFT      = 14;
   localparam int         PEND_W         = 20;
   localparam int         DIV_W          = 7;
   localparam int         PER_W          = 8;
   localparam int         TMR_W          = 16;
   // Timing
   localparam int         SW_DELAY_US    = 250;
   localparam int         CLK_PERIOD_NS  = 40;
   localparam int         SW_DELAY_CYC   =
      (SW_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Reset values
   localparam logic [1:0] GRAY_RST       = 2'h0;
   localparam logic [1:0] STATUS_RST     = 2'h0;
   // Top-level path state, one-hot
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_HW  = 3'b010,
      ST_SW  = 3'b100
   } esim_state_e;
endpackage : esim_pkg
`default_nettype wire

// >>> rtl/esim_pulse_gen.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Output line generator: quadrature, freq/dir, fwd/rev
// ****************************************************************
module esim_pulse_gen (
   input  wire logic       clk_i,    // Drive clock
   input  wire logic       rst_n_i,  // Synchronised reset, active low
   input  wire logic       en_i,     // Output path active
   input  wire logic       step_i,   // One output count
   input  wire logic       up_i,     // Count direction, 1 = forward
   input  wire logic [1:0] fmt_i,    // Output format
   input  wire logic       align_i,  // Marker realign request
   output logic            a_o,      // A / F / forward line
   output logic            b_o       // B / D / reverse line
);
   logic [1:0] gray_reg;

   // Quadrature state, advanced one Gray step per count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gray_reg <= esim_pkg::GRAY_RST;
      end else if (!en_i) begin
         gray_reg <= esim_pkg::GRAY_RST;
      end else if (align_i) begin
         gray_reg <= 2'h3;
      end else if (step_i) begin
         if (up_i) begin
            gray_reg <= {gray_reg[0], ~gray_reg[1]};
         end else begin
            gray_reg <= {~gray_reg[0], gray_reg[1]};
         end
      end
   end

   // Line drive per format
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_o <= 1'b0;
         b_o <= 1'b0;
      end else if (!en_i) begin
         a_o <= 1'b0;
         b_o <= 1'b0;
      end else begin
         unique case (fmt_i)
            esim_pkg::FMT_FD: begin
               if (align_i) begin
                  a_o <= 1'b1;
               end else if (step_i) begin
                  a_o <= ~a_o;
                  b_o <= up_i;
               end
            end
            esim_pkg::FMT_FR: begin
               if (align_i) begin
                  a_o <= 1'b1;
               end else if (step_i && up_i) begin
                  a_o <= ~a_o;
               end else if (step_i) begin
                  b_o <= ~b_o;
               end
            end
            default: begin
               if (align_i) begin
                  a_o <= 1'b1;
                  b_o <= 1'b1;
               end else if (step_i) begin
                  if (up_i) begin
                     a_o <= gray_reg[0];
                     b_o <= ~gray_reg[1];
                  end else begin
                     a_o <= ~gray_reg[0];
                     b_o <= gray_reg[1];
                  end
               end else begin
                  a_o <= gray_reg[1];
                  b_o <= gray_reg[0];
               end
            end
         endcase
      end
   end
endmodule : esim_pulse_gen
`default_nettype wire

// >>> rtl/esim_top.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Status 0 when off, 1 with marker
// - Status 2 when no marker possible
// - Hardware mode: direct logic from primary pins
// - Hardware output only for supported device types
// - Sine-cosine: zero crossings only, no interpolation
// - Mode value 0 selects hardware mode
// - Divider code n scales by 1/2^n
// - Lock clear: marker output copies marker input
// - Lock set: realign A high on marker, B too in quad format
// - Format 0 quad, 1 freq/dir, 2 fwd/rev
// - Software mode: sample every 250 us or longer
// - Software resolution from lines per revolution
// - Mode value 1 selects lines-per-rev mode
// - Lines per revolution limited to 16384
// - Freq formats emit twice lines pulses
// - Software source: primary, secondary or other
module esim_top #(
   parameter int SW_DELAY_CYCLES = esim_pkg::SW_DELAY_CYC // Sample base
) (
   input  wire logic        REF_CLK_I,        // Drive clock, 25 MHz
   input  wire logic        ARST_N_I,         // Async reset, active low
   input  wire logic        SIM_ENABLE_I,     // Simulation output enable
   input  wire logic [1:0]  SIM_MODE_I,       // Simulation mode
   input  wire logic [1:0]  OUT_FORMAT_I,     // Output format
   input  wire logic [1:0]  SIM_SOURCE_I,     // Position source select
   input  wire logic [2:0]  HW_DIVIDER_I,     // Hardware divider code
   input  wire logic        MARKER_LOCK_I,    // Hardware marker lock
   input  wire logic [2:0]  INPUT_DEVICE_I,   // Primary device type
   input  wire logic        MARKER_PRESENT_I, // Primary has a marker
   input  wire logic [14:0] OUT_LINES_I,      // Output lines per rev
   input  wire logic [7:0]  SAMPLE_PERIOD_I,  // Extra sample periods
   input  wire logic        PRI_A_I,          // Primary A / F / sine pin
   input  wire logic        PRI_B_I,          // Primary B / D / cos pin
   input  wire logic        PRI_Z_I,          // Primary marker pin
   input  wire logic [15:0] PRI_POS_I,        // Primary position word
   input  wire logic [15:0] SEC_POS_I,        // Secondary position word
   input  wire logic [15:0] AUX_POS_I,        // Other position reference
   output logic             OUT_A_O,          // Simulated A / F / fwd
   output logic             OUT_B_O,          // Simulated B / D / rev
   output logic             OUT_Z_O,          // Simulated marker
   output logic [1:0]       STATUS_O          // Simulation status
);
   // ****************************************************************
   // Reset release and pin synchronisers
   // ****************************************************************
   logic rst_meta_reg, rst_n;
   logic [2:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;

   // Reset release through two flip-flops
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // Two-stage pin sync, then a delayed copy for edges
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
         pin_prev_reg <= 3'h0;
      end else begin
         pin_meta_reg <= {PRI_Z_I, PRI_B_I, PRI_A_I};
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // ****************************************************************
   // Path selection and status
   // ****************************************************************
   esim_pkg::esim_state_e state_reg, state_next;
   logic dev_ok;
   logic [1:0] status_next;

   // Supported primary device types for hardware mode
   assign dev_ok = (INPUT_DEVICE_I == esim_pkg::DEV_QUAD) ||
                   (INPUT_DEVICE_I == esim_pkg::DEV_FD) ||
                   (INPUT_DEVICE_I == esim_pkg::DEV_FR) ||
                   (INPUT_DEVICE_I == esim_pkg::DEV_SINE_COS) ||
                   (INPUT_DEVICE_I == esim_pkg::DEV_SINE_COS_SER);

   // Next path and status from configuration
   always_comb begin
      state_next  = esim_pkg::ST_OFF;
      status_next = esim_pkg::STAT_NONE;
      if (SIM_ENABLE_I && OUT_FORMAT_I != 2'h3) begin
         if (SIM_MODE_I == esim_pkg::MODE_HW && dev_ok &&
             SIM_SOURCE_I == esim_pkg::SRC_PRIMARY) begin
            state_next  = esim_pkg::ST_HW;
            status_next = MARKER_PRESENT_I ? esim_pkg::STAT_FULL
                                           : esim_pkg::STAT_NO_MARKER;
         end else if (SIM_MODE_I == esim_pkg::MODE_LPR &&
                      SIM_SOURCE_I != 2'h3) begin
            state_next  = esim_pkg::ST_SW;
            status_next = esim_pkg::STAT_NO_MARKER;
         end
      end
   end

   // Path state and status registers
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= esim_pkg::ST_OFF;
         STATUS_O  <= esim_pkg::STATUS_RST;
      end else begin
         state_reg <= state_next;
         STATUS_O  <= status_next;
      end
   end

   // ****************************************************************
   // Hardware path: edge decode and divider
   // ****************************************************************
   logic       in_step, in_up;
   logic [1:0] idx_new, idx_old, idx_diff;
   logic [6:0] div_mask, div_cnt_reg;
   logic       hw_step_reg, hw_up_reg, hw_align_reg;

   // Gray index of old and new A/B levels
   assign idx_new  = {pin_sync_reg[0], pin_sync_reg[0] ^ pin_sync_reg[1]};
   assign idx_old  = {pin_prev_reg[0], pin_prev_reg[0] ^ pin_prev_reg[1]};
   assign idx_diff = idx_new - idx_old;
   assign div_mask = 7'((8'h1 << HW_DIVIDER_I) - 8'h1);

   // Input edge decode per device type
   always_comb begin
      in_step = 1'b0;
      in_up   = 1'b0;
      unique case (INPUT_DEVICE_I)
         esim_pkg::DEV_FD: begin
            in_step = pin_sync_reg[0] & ~pin_prev_reg[0];
            in_up   = pin_sync_reg[1];
         end
         esim_pkg::DEV_FR: begin
            in_step = (pin_sync_reg[0] & ~pin_prev_reg[0]) ^
                      (pin_sync_reg[1] & ~pin_prev_reg[1]);
            in_up   = pin_sync_reg[0] & ~pin_prev_reg[0];
         end
         default: begin
            // Comparator zero crossings only
            in_step = (idx_diff == 2'h1) || (idx_diff == 2'h3);
            in_up   = (idx_diff == 2'h1);
         end
      endcase
   end

   // Divider counter and registered output step
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg <= 7'h00;
         hw_step_reg <= 1'b0;
         hw_up_reg   <= 1'b0;
      end else if (state_reg != esim_pkg::ST_HW) begin
         div_cnt_reg <= 7'h00;
         hw_step_reg <= 1'b0;
         hw_up_reg   <= 1'b0;
      end else if (in_step && in_up) begin
         div_cnt_reg <= div_cnt_reg + 7'h01;
         hw_step_reg <= (div_cnt_reg & div_mask) == div_mask;
         hw_up_reg   <= 1'b1;
      end else if (in_step) begin
         div_cnt_reg <= div_cnt_reg - 7'h01;
         hw_step_reg <= (div_cnt_reg & div_mask) == 7'h00;
         hw_up_reg   <= 1'b0;
      end else begin
         hw_step_reg <= 1'b0;
      end
   end

   // Marker output and realign request
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         OUT_Z_O      <= 1'b0;
         hw_align_reg <= 1'b0;
      end else begin
         OUT_Z_O      <= (state_reg == esim_pkg::ST_HW) &
                         pin_sync_reg[2];
         hw_align_reg <= (state_reg == esim_pkg::ST_HW) & MARKER_LOCK_I &
                         pin_sync_reg[2] & ~pin_prev_reg[2];
      end
   end

   // ****************************************************************
   // Software path: resampling and resolution scaling
   // ****************************************************************
   logic [15:0] sel_pos, last_pos_reg;
   logic [14:0] lines_eff;
   logic [esim_pkg::TMR_W-1:0] base_tmr_reg;
   logic [7:0]  ext_tmr_reg;
   logic        sw_sample;
   logic signed [31:0] acc_reg, acc_next, acc_add;
   logic signed [19:0] pend_reg, pend_add;
   logic        sw_step, sw_up;

   // Source select
   always_comb begin
      unique case (SIM_SOURCE_I)
         esim_pkg::SRC_SECONDARY: sel_pos = SEC_POS_I;
         esim_pkg::SRC_AUX:       sel_pos = AUX_POS_I;
         default:                 sel_pos = PRI_POS_I;
      endcase
   end

   // Clamp resolution
   assign lines_eff = (OUT_LINES_I > esim_pkg::LINES_MAX) ?
                      esim_pkg::LINES_MAX : OUT_LINES_I;
   // Position delta times lines, four counts per line
   assign acc_add  = 32'(signed'(last_pos_reg - sel_pos) * -32'sd1 *
                         signed'({17'h00000, lines_eff}));
   assign acc_next = acc_reg + acc_add;
   assign pend_add = 20'((acc_next >>> esim_pkg::ACC_SHIFT) -
                         (acc_reg >>> esim_pkg::ACC_SHIFT));
   assign sw_sample = (base_tmr_reg == 16'h0000) &&
                      (ext_tmr_reg == 8'h00);
   assign sw_step  = (state_reg == esim_pkg::ST_SW) && (pend_reg != 20'sd0);
   assign sw_up    = !pend_reg[19];

   // Sample timer: base period times (1 + extension)
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         base_tmr_reg <= 16'(SW_DELAY_CYCLES - 1);
         ext_tmr_reg  <= 8'h00;
      end else if (state_reg != esim_pkg::ST_SW || sw_sample) begin
         base_tmr_reg <= 16'(SW_DELAY_CYCLES - 1);
         ext_tmr_reg  <= SAMPLE_PERIOD_I;
      end else if (base_tmr_reg == 16'h0000) begin
         base_tmr_reg <= 16'(SW_DELAY_CYCLES - 1);
         ext_tmr_reg  <= ext_tmr_reg - 8'h01;
      end else begin
         base_tmr_reg <= base_tmr_reg - 16'h0001;
      end
   end

   // Accumulator and pending output counts
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         last_pos_reg <= 16'h0000;
         acc_reg      <= 32'sd0;
         pend_reg     <= 20'sd0;
      end else if (state_reg != esim_pkg::ST_SW) begin
         last_pos_reg <= sel_pos;
         acc_reg      <= 32'sd0;
         pend_reg     <= 20'sd0;
      end else begin
         if (sw_sample) begin
            last_pos_reg <= sel_pos;
            acc_reg      <= acc_next;
         end
         pend_reg <= pend_reg + (sw_sample ? pend_add : 20'sd0) -
                     (sw_step ? (sw_up ? 20'sd1 : -20'sd1) : 20'sd0);
      end
   end

   // ****************************************************************
   // Output line generator
   // ****************************************************************
   logic gen_step, gen_up;
   assign gen_step = (state_reg == esim_pkg::ST_HW) ? hw_step_reg : sw_step;
   assign gen_up   = (state_reg == esim_pkg::ST_HW) ? hw_up_reg : sw_up;

   esim_pulse_gen u_gen (
      .clk_i   (REF_CLK_I),
      .rst_n_i (rst_n),
      .en_i    (state_reg != esim_pkg::ST_OFF),
      .step_i  (gen_step),
      .up_i    (gen_up),
      .fmt_i   (OUT_FORMAT_I),
      .align_i (hw_align_reg),
      .a_o     (OUT_A_O),
      .b_o     (OUT_B_O)
   );

   // ****************************************************************
   // Assertions and covers
   // ****************************************************************
   logic [15:0] gap_reg;
   // Cycles since last software sample, saturating
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg <= 16'h0000;
      end else if (sw_sample || state_reg != esim_pkg::ST_SW) begin
         gap_reg <= 16'h0000;
      end else if (gap_reg != 16'hffff) begin
         gap_reg <= gap_reg + 16'h0001;
      end
   end

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!rst_n);

   a_status_off: assert property (
      !SIM_ENABLE_I |=> STATUS_O == esim_pkg::STAT_NONE)
      else $error("status not zero while disabled");
   a_status_nomark: assert property (
      SIM_ENABLE_I && SIM_MODE_I == esim_pkg::MODE_LPR &&
      OUT_FORMAT_I != 2'h3 && SIM_SOURCE_I != 2'h3
      |=> STATUS_O == esim_pkg::STAT_NO_MARKER)
      else $error("software mode status not two");
   a_hw_unsup: assert property (
      !dev_ok |=> state_reg != esim_pkg::ST_HW)
      else $error("hardware path with unsupported device");
   a_hw_latency: assert property (
      state_reg == esim_pkg::ST_HW && $stable(state_reg) && hw_step_reg &&
      !hw_align_reg && OUT_FORMAT_I == esim_pkg::FMT_QUAD &&
      $stable(OUT_FORMAT_I)
      |=> {OUT_A_O, OUT_B_O} != $past({OUT_A_O, OUT_B_O}))
      else $error("hardware step not on lines next cycle");
   a_div_wrap: assert property (
      hw_step_reg && hw_up_reg && $stable(HW_DIVIDER_I) |->
      (div_cnt_reg & div_mask) == 7'h00)
      else $error("divider step off a 2^n boundary");
   a_marker_copy: assert property (
      state_reg == esim_pkg::ST_HW && !MARKER_LOCK_I |=>
      OUT_Z_O == $past(pin_sync_reg[2]))
      else $error("marker output not a copy");
   a_lock_align: assert property (
      hw_align_reg && state_reg == esim_pkg::ST_HW && $stable(state_reg)
      |=> OUT_A_O && (OUT_B_O || $past(OUT_FORMAT_I) != esim_pkg::FMT_QUAD))
      else $error("lines not realigned on marker");
   a_fd_dir: assert property (
      gen_step && !hw_align_reg && state_reg != esim_pkg::ST_OFF &&
      $stable(state_reg) && OUT_FORMAT_I == esim_pkg::FMT_FD
      |=> OUT_B_O == $past(gen_up))
      else $error("direction line wrong");
   a_sample_gap: assert property (
      sw_sample && state_reg == esim_pkg::ST_SW && $past(state_reg) ==
      esim_pkg::ST_SW |-> gap_reg >= 16'(SW_DELAY_CYCLES - 1))
      else $error("software sample too early");
   a_lines_max: assert property (
      lines_eff <= esim_pkg::LINES_MAX)
      else $error("lines above limit");
   a_quad_gray: assert property (
      gen_step && !hw_align_reg && state_reg != esim_pkg::ST_OFF &&
      $stable(state_reg) && OUT_FORMAT_I == esim_pkg::FMT_QUAD &&
      $stable(OUT_FORMAT_I)
      |=> $countones({OUT_A_O, OUT_B_O} ^ $past({OUT_A_O, OUT_B_O})) == 1)
      else $error("quadrature step not one Gray state");

   c_hw_step:  cover property (state_reg == esim_pkg::ST_HW && hw_step_reg);
   c_sw_step:  cover property (sw_sample ##[1:50] sw_step);
   c_align:    cover property (hw_align_reg);
   c_fr_step:  cover property (gen_step && OUT_FORMAT_I == esim_pkg::FMT_FR);
endmodule : esim_top
`default_nettype wire

// >>> testbench/esim_ctr.sv
`timescale 1ns/1ns
`default_nettype none
module esim_ctr (
   input  wire logic        clk_i, // Drive clock
   input  wire logic        a_i,   // A / F / forward line
   input  wire logic        b_i,   // B / D / reverse line
   input  wire logic [1:0]  fmt_i, // Format being counted
   output logic      [31:0] cnt_o  // Signed position count
);
   logic [31:0] cnt_q = 32'h0;
   logic        pa = 1'b0;
   logic        pb = 1'b0;
   assign cnt_o = cnt_q;
   // Count one step per line event; quad up runs 00,01,11,10
   always @(posedge clk_i) begin
      if (fmt_i == 2'h0 && {pa, pb} != {a_i, b_i})
         cnt_q <= cnt_q + ((b_i ^ pa) ? 32'h1 : 32'hffffffff);
      if (fmt_i == 2'h1 && pa != a_i)
         cnt_q <= cnt_q + (b_i ? 32'h1 : 32'hffffffff);
      if (fmt_i == 2'h2 && pa != a_i)
         cnt_q <= cnt_q + 32'h1;
      if (fmt_i == 2'h2 && pb != b_i)
         cnt_q <= cnt_q - 32'h1;
      pa <= a_i;
      pb <= b_i;
   end
endmodule : esim_ctr
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 0, rst_n = 0, en = 1, lock = 0, mp = 1, pa = 0, pb = 0;
   logic pz = 0, oa, ob, oz;
   logic [1:0] mode = 0, fmt = 0, src = 0, st, qi = 0;
   logic [2:0] div = 0, dev = 1;
   logic [14:0] lines = 0;
   logic [7:0] sp = 0;
   logic [15:0] pos [3] = '{default: 16'h0};
   logic [31:0] x = 32'h2dab, cnt;
   int bad_count = 0, n_tests = 0, cyc = 0;
   esim_top #(.SW_DELAY_CYCLES(20)) dut_u (.REF_CLK_I(clk),
      .ARST_N_I(rst_n), .SIM_ENABLE_I(en), .SIM_MODE_I(mode),
      .OUT_FORMAT_I(fmt), .SIM_SOURCE_I(src), .HW_DIVIDER_I(div),
      .MARKER_LOCK_I(lock), .INPUT_DEVICE_I(dev), .MARKER_PRESENT_I(mp),
      .OUT_LINES_I(lines), .SAMPLE_PERIOD_I(sp), .PRI_A_I(pa),
      .PRI_B_I(pb), .PRI_Z_I(pz), .PRI_POS_I(pos[0]), .SEC_POS_I(pos[1]),
      .AUX_POS_I(pos[2]), .OUT_A_O(oa), .OUT_B_O(ob), .OUT_Z_O(oz),
      .STATUS_O(st));
   esim_ctr ctr_u (.clk_i(clk), .a_i(oa), .b_i(ob), .fmt_i(fmt),
      .cnt_o(cnt));
   // Clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         results();
      end
   end
   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : rnd
   // Status the settings should give
   function automatic logic [1:0] stat_exp();
      if (!en || mode > 2'h1 || fmt == 2'h3 || src == 2'h3)
         return esim_pkg::STAT_NONE;
      if (mode == esim_pkg::MODE_LPR) return esim_pkg::STAT_NO_MARKER;
      if (src != 2'h0 || dev == 3'h0 || dev > 3'h5)
         return esim_pkg::STAT_NONE;
      return mp ? esim_pkg::STAT_FULL : esim_pkg::STAT_NO_MARKER;
   endfunction : stat_exp
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   // One quadrature state on the primary pins, held 3 cycles
   task automatic pstep(input logic [1:0] d);
      qi = qi + d;
      pa = qi[1];
      pb = qi[1] ^ qi[0];
      tick(3);
   endtask : pstep
   // One pulse on the primary pins in mask m, 3 cycles high, 3 low
   task automatic ppulse(input logic [1:0] m);
      {pb, pa} = {pb, pa} | m;
      tick(3);
      {pb, pa} = {pb, pa} & ~m;
      tick(3);
   endtask : ppulse
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   // Main sequence
   initial begin
      logic [31:0] b, d, n;
      tick(10);
      rst_n = 1;
      tick(4);
      for (int f = 0; f < 3; f++) begin
         fmt = f[1:0];
         dev = f[0] ? esim_pkg::DEV_SINE_COS : esim_pkg::DEV_QUAD;
         div = 3'(rnd());
         if (f == 2) div = 3'h7;
         n = (32'h1 + rnd() % 4) << div;
         tick(8);
         b = cnt;
         repeat (n) pstep(2'h1);
         tick(8);
         chk(cnt - b, n >> div);
         b = cnt;
         repeat (n) pstep(2'h3);
         tick(8);
         chk(b - cnt, n >> div);
      end
      // Freq/dir then fwd/rev primary inputs at 1/1
      {fmt, div} = {esim_pkg::FMT_QUAD, 3'h0};
      for (int t = 0; t < 2; t++) begin
         dev = t[0] ? esim_pkg::DEV_FR : esim_pkg::DEV_FD;
         {pb, pa} = 2'b10;
         tick(8);
         b = cnt;
         n = rnd() % 16 + 1;
         repeat (n) ppulse(2'b01);
         tick(8);
         chk(cnt - b, n);
         pb = 1'b0;
         tick(8);
         b = cnt;
         repeat (n) ppulse(t[0] ? 2'b10 : 2'b01);
         tick(8);
         chk(b - cnt, n);
      end
      mode = esim_pkg::MODE_LPR;
      lines = 15'h7fff; // Clamped: one count per position unit
      for (int k = 0; k < 3; k++) begin
         src = k[1:0];
         fmt = 2'(rnd() % 3);
         sp = k[7:0];
         tick(400);
         b = cnt;
         d = rnd() % 200 + 1;
         if (rnd() % 2 == 0) d = -d;
         pos[k] = pos[k] + d[15:0];
         tick(400);
         chk(cnt - b, d);
         pos = '{default: pos[k]};
      end
      repeat (40) begin
         en = (rnd() % 4) != 0;
         mode = 2'(rnd());
         fmt = 2'(rnd());
         src = 2'(rnd());
         if (mode == 2'h0) src = 2'h0;
         dev = 3'(rnd());
         mp = 1'(rnd());
         tick(3);
         chk({30'h0, st}, {30'h0, stat_exp()});
      end
      {en, mode, fmt, src, dev, mp} = {1'b1, 2'h0, 2'h0, 2'h0, 3'h1, 1'b1};
      for (int z = 0; z < 4; z++) begin
         pz = z[0];
         tick(8);
         chk({31'h0, oz}, {31'h0, pz});
      end
      lock = 1;
      for (int f = 0; f < 3; f++) begin
         fmt = f[1:0];
         pz = 0;
         tick(8);
         pz = 1;
         tick(8);
         chk({30'h0, oa, ob | f[0] | f[1]}, 32'h3);
         pz = 0;
         tick(4);
      end
      results();
   end
endmodule : tb_top
`default_nettype wire
